// ==== rtl/dfc_pkg.sv ====
// Constants for the drive fault clear command handler.
// Assumes a single 20 MHz system clock and synchronous active-low reset.
package dfc_pkg;
	localparam int          DFC_WORD_W       = 16;
	localparam int          DFC_ADDR_W       = 11;
	localparam logic [10:0] DFC_REG_CMD_LOW  = 11'h400;
	localparam logic [10:0] DFC_REG_CMD_HIGH = 11'h401;
	localparam int          DFC_BIT_RESET    = 10;
	localparam int          DFC_BIT_CLRFLT   = 10;
	localparam int          DFC_BIT_DRV_EN   = 15;
	localparam int          DFC_BIT_FAULT    = 7;
	localparam int          DFC_BIT_CMDERR   = 12;
	localparam logic [15:0] DFC_WORD_ZERO    = 16'h0000;
	localparam logic [15:0] DFC_RESET_BLOCK  = 16'h0400;

	typedef enum logic [1:0] {
		DFC_IDLE,
		DFC_HAVE_LOW,
		DFC_EXEC
	} dfc_state_t;
endpackage : dfc_pkg

// ==== rtl/dfc_flag.sv ====
// Sticky status flag where the set wins over the clear.
// Assumes synchronous active-low reset on clk_sys.
module dfc_flag (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_q
);
	logic flag_d;

	always_comb begin
		flag_d = flag_q;
		if (clr_i) begin
			flag_d = 1'b0;
		end
		if (set_i) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule : dfc_flag

// ==== rtl/dfc_core.sv ====
// Command block handler that latches and clears the motor driver fault.
// Assumes command words arrive as single-cycle writes from the network side.

// What this block does
// - A driver over-temperature or motor short raises a drive fault.
// - A drive fault sets bit 7 of the second status word until cleared.
// - Command words two to nine are ignored in a fault-clear block.
// - Accepting the fault-clear block clears bit 7 of status word two.
// - After a clear, motor current stays off while drive enable is zero.
// - Setting drive enable in a later block restores motor current.
// - Bit 10 of word one, with bit 10 of word zero set, clears the fault only with drive enable low.
// - Bit 10 of word zero resets latched errors like the command error.
// - The fault flag is set only while in the drive_power_on_state, then holds.
module dfc_core (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         wr_en,
	input  wire logic [dfc_pkg::DFC_ADDR_W-1:0] wr_addr,
	input  wire logic [dfc_pkg::DFC_WORD_W-1:0] wr_data,
	input  wire logic                         over_temp,
	input  wire logic                         short_circuit,
	input  wire logic                         cmd_error_evt,
	output logic [dfc_pkg::DFC_WORD_W-1:0]    status_word_low,
	output logic [dfc_pkg::DFC_WORD_W-1:0]    status_word_high,
	output logic                              motor_current_on,
	output logic                              block_done
);
	import dfc_pkg::*;

	dfc_state_t  state_q, state_d;
	logic [15:0] low_q, low_d;
	logic [15:0] high_q, high_d;
	logic        drive_power_on_state_q, drive_power_on_state_d;
	logic        done_q, done_d;
	logic        fault_raw;
	logic        fault_q;
	logic        cmderr_q;
	logic        do_reset;
	logic        do_clear;

	// Only newly written words advance the block; held data does nothing.
	always_comb begin
		state_d = state_q;
		low_d   = low_q;
		high_d  = high_q;
		unique case (state_q)
			DFC_IDLE, DFC_EXEC: begin
				state_d = DFC_IDLE;
				if (wr_en && wr_addr == DFC_REG_CMD_LOW) begin
					low_d   = wr_data;
					state_d = DFC_HAVE_LOW;
				end
			end
			DFC_HAVE_LOW: begin
				if (wr_en && wr_addr == DFC_REG_CMD_HIGH) begin
					high_d  = wr_data;
					state_d = DFC_EXEC;
				end else if (wr_en && wr_addr == DFC_REG_CMD_LOW) begin
					low_d = wr_data;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= DFC_IDLE;
			low_q   <= DFC_WORD_ZERO;
			high_q  <= DFC_WORD_ZERO;
		end else begin
			state_q <= state_d;
			low_q   <= low_d;
			high_q  <= high_d;
		end
	end

	// Words beyond the first two are never decoded here.
	assign do_reset = (state_q == DFC_EXEC) && low_q[DFC_BIT_RESET];
	assign do_clear = do_reset && high_q[DFC_BIT_CLRFLT]
		&& !high_q[DFC_BIT_DRV_EN];

	always_comb begin
		drive_power_on_state_d = drive_power_on_state_q;
		done_d                 = (state_q == DFC_EXEC);
		if (state_q == DFC_EXEC) begin
			drive_power_on_state_d = high_q[DFC_BIT_DRV_EN];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			drive_power_on_state_q <= 1'b0;
			done_q                 <= 1'b0;
		end else begin
			drive_power_on_state_q <= drive_power_on_state_d;
			done_q                 <= done_d;
		end
	end

	// The fault is only seen while the driver section is enabled.
	assign fault_raw = drive_power_on_state_q
		&& (over_temp || short_circuit);

	dfc_flag u_fault (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set_i   (fault_raw),
		.clr_i   (do_clear),
		.flag_q  (fault_q)
	);

	dfc_flag u_cmderr (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set_i   (cmd_error_evt),
		.clr_i   (do_reset),
		.flag_q  (cmderr_q)
	);

	always_comb begin
		status_word_low                 = DFC_WORD_ZERO;
		status_word_low[DFC_BIT_CMDERR] = cmderr_q;
		status_word_high                = DFC_WORD_ZERO;
		status_word_high[DFC_BIT_FAULT] = fault_q;
		status_word_high[DFC_BIT_DRV_EN] = drive_power_on_state_q;
	end

	// Current flows only when enabled and no fault is latched.
	assign motor_current_on = drive_power_on_state_q && !fault_q;
	assign block_done       = done_q;

	a_fault_sets: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		fault_raw |=> status_word_high[DFC_BIT_FAULT])
		else $error("fault not latched");

	a_raise_fault: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(drive_power_on_state_q && (over_temp || short_circuit))
		|=> fault_q)
		else $error("driver fault not raised");

	a_fault_clears: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(do_clear && !fault_raw) |=> !status_word_high[DFC_BIT_FAULT])
		else $error("fault not cleared");

	a_fault_holds: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(fault_q && !do_clear) |=> fault_q)
		else $error("fault dropped early");

	a_clear_needs_off: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		($fell(fault_q) && $past(rst_n))
		|-> ($past(do_clear) && !drive_power_on_state_q))
		else $error("fault dropped without a clear block");

	a_current_off: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		!drive_power_on_state_q |-> !motor_current_on)
		else $error("current on while disabled");

	a_enable_restores: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(state_q == DFC_EXEC && high_q[DFC_BIT_DRV_EN] && !fault_q
		&& !over_temp && !short_circuit) |=> motor_current_on)
		else $error("current not restored");

	a_no_repeat: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		state_q == DFC_EXEC |=> state_q != DFC_EXEC)
		else $error("block executed twice");

	a_done_pulse: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		state_q == DFC_EXEC |=> block_done ##1 !block_done)
		else $error("done pulse wrong");

	a_reset_errs: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(do_reset && !cmd_error_evt) |=> !status_word_low[DFC_BIT_CMDERR])
		else $error("command error not reset");

	a_enabled_fault: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(!drive_power_on_state_q && !fault_q) |=> !fault_q)
		else $error("fault set while disabled");

	a_clear_gate: assert property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		(state_q == DFC_EXEC && high_q[DFC_BIT_DRV_EN] && fault_q)
		|=> fault_q)
		else $error("clear with drive enable set");

	c_fault_raised: cover property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		$rose(fault_q));

	c_fault_cleared: cover property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		fault_q ##1 !fault_q);

	c_reenable: cover property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		!motor_current_on ##[1:20] motor_current_on);

	c_block_exec: cover property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		state_q == DFC_HAVE_LOW ##1 state_q == DFC_EXEC);

	c_clear_refused: cover property (
		@(posedge clk_sys)
		disable iff (!rst_n)
		state_q == DFC_EXEC && high_q[DFC_BIT_DRV_EN] && fault_q);
endmodule : dfc_core

// ==== tb/dfc_host_model.sv ====
// Host model that writes command blocks to the command handler.
// Assumes the bench calls send_block and nothing else drives this bus.
module dfc_host_model (
	input  wire logic        clk_sys,
	output logic             wr_en,
	output logic [10:0]      wr_addr,
	output logic [15:0]      wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_en = 1'b0;
		wr_addr = 11'h000;
		wr_data = 16'h0000;
	end
	task automatic put(input logic [10:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
	endtask : put
	task automatic send_block(input logic [15:0] lo, hi, fill);
		put(11'h400, lo);
		for (int i = 2; i < 10; i++) put(11'h400 + i[10:0], fill ^ i[15:0]);
		put(11'h401, hi);
		release_bus();
	endtask : send_block
	task automatic release_bus;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		wr_addr <= ~wr_addr;
		wr_data <= ~wr_data;
	endtask : release_bus
endmodule : dfc_host_model

// ==== tb/dfc_core_test.sv ====
// Self-checking bench for the drive fault clear command handler.
// Assumes the host model writes blocks and the bench drives fault inputs.
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
	n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module dfc_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dfc_pkg::*;
	logic        clk_sys, rst_n, wr_en, over_temp, short_circuit;
	logic        cmd_error_evt, motor_current_on, block_done, pick;
	logic [10:0] wr_addr;
	logic [15:0] wr_data, status_word_low, status_word_high;
	int          n_errors = 0;
	int          n_compared = 0;
	integer      seed = 32'h7bc844e6;
	dfc_host_model host (.clk_sys(clk_sys), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data));
	dfc_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .over_temp(over_temp),
		.short_circuit(short_circuit), .cmd_error_evt(cmd_error_evt),
		.status_word_low(status_word_low), .status_word_high(status_word_high),
		.motor_current_on(motor_current_on), .block_done(block_done));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic complete_run;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	function automatic logic [15:0] hi_exp(input logic flt, en);
		return {en, 7'h00, flt, 7'h00};
	endfunction : hi_exp
	task automatic block(input logic [15:0] lo, hi, input logic flt, en);
		int k;
		host.send_block(lo, hi, 16'($random(seed)));
		for (k = 0; k < 8 && block_done !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("status_high", hi_exp(flt, en), status_word_high)
		`CHK("motor", en & ~flt, motor_current_on)
		if (block_done !== 1'b1) begin
			n_errors++;
			complete_run;
		end
	endtask : block
	initial begin
		rst_n = 1'b0;
		over_temp = 1'b0;
		short_circuit = 1'b0;
		cmd_error_evt = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		`CHK("motor_rst", 1'b0, motor_current_on)
		block(16'h0000, 16'h8000, 1'b0, 1'b1);
		pick = 1'($random(seed));
		@(posedge clk_sys);
		over_temp <= pick;
		short_circuit <= ~pick;
		repeat (3) @(posedge clk_sys);
		over_temp <= 1'b0;
		short_circuit <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("fault", hi_exp(1'b1, 1'b1), status_word_high)
		`CHK("motor_flt", 1'b0, motor_current_on)
		block(16'h0400, 16'h8400, 1'b1, 1'b1);
		block(16'h0400, 16'h0400, 1'b0, 1'b0);
		@(posedge clk_sys);
		over_temp <= 1'b1;
		repeat (20) @(posedge clk_sys);
		over_temp <= 1'b0;
		#1;
		`CHK("idle_hi", 16'h0000, status_word_high)
		`CHK("idle_motor", 1'b0, motor_current_on)
		block(16'h0000, 16'h8000, 1'b0, 1'b1);
		@(posedge clk_sys);
		cmd_error_evt <= 1'b1;
		@(posedge clk_sys);
		cmd_error_evt <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("cmd_err", 16'h1000, status_word_low)
		block(16'h0400, 16'h8000, 1'b0, 1'b1);
		`CHK("cmd_err_clr", 16'h0000, status_word_low)
		host.put(11'h401, 16'h0400);
		host.release_bus();
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK("held_hi", hi_exp(1'b0, 1'b1), status_word_high)
		`CHK("held_motor", 1'b1, motor_current_on)
		complete_run;
	end
endmodule : dfc_core_test
